/* File: dfc_pkg.sv */
// Constants, carrier types and state records for the DMA flag-clear block.
`default_nettype none

package dfc_pkg;

    localparam int          NUM_CH          = 8;
    localparam int          FLAGS_PER_CH    = 4;

    // Byte addresses on the APB bus
    localparam logic [31:0] DMA_BASE        = 32'ha000_0000;
    localparam logic [31:0] STATUS_OFFSET   = 32'h0000_0000;
    localparam logic [31:0] CLEAR_OFFSET    = 32'h0000_0004;
    localparam logic [31:0] CH0_BASE        = 32'ha000_0008;
    localparam logic [31:0] CH_STRIDE       = 32'h0000_0014;
    localparam logic [31:0] CH_LAST_BASE    = 32'ha000_0094;
    localparam logic [31:0] MASK_OFFSET     = 32'h0000_00a8;
    localparam logic [2:0]  CH_WORDS        = 3'h4;

    // Field positions inside one channel nibble
    localparam int          ANY_BIT         = 0;
    localparam int          COMPLETE_BIT    = 1;
    localparam int          HALF_BIT        = 2;
    localparam int          ERROR_BIT       = 3;

    // Reset values
    localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
    localparam logic [31:0] CLEAR_RESET     = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET      = 32'h0000_0000;

    // One-cycle event pulses of a channel
    typedef struct packed {
        logic error;
        logic half;
        logic complete;
    } dfc_evt_t;

    // One channel nibble, bit 3 down to bit 0
    typedef struct packed {
        logic error;
        logic half;
        logic complete;
        logic any_event;
    } dfc_flags_t;

    typedef struct packed {
        logic       hit;
        logic [2:0] idx;
        logic [2:0] word;
    } dfc_chan_hit_t;

    typedef struct packed {
        dfc_flags_t flags;
    } dfc_cell_state_t;

    typedef struct packed {
        logic [31:0] mask;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        chan_req;
        logic        chan_write;
        logic [2:0]  chan_idx;
        logic [2:0]  chan_word;
        logic [31:0] chan_wdata;
    } dfc_top_state_t;

endpackage

`default_nettype wire

/* File: dfc_flag_cell.sv */
// Status flags of one DMA channel with their set and clear logic.
`default_nettype none

module dfc_flag_cell
    import dfc_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire dfc_evt_t   evt,
    input  wire logic       clr_en,
    input  wire dfc_flags_t clr,
    output var  dfc_flags_t flags
);

    dfc_cell_state_t state_reg;
    dfc_cell_state_t state_next;
    dfc_flags_t      set_mask;
    dfc_flags_t      clr_mask;

    always_comb begin
        set_mask           = '0;
        set_mask.complete  = evt.complete;
        set_mask.half      = evt.half;
        set_mask.error     = evt.error;
        set_mask.any_event = evt.complete | evt.half | evt.error;

        clr_mask = '0;
        if (clr_en) begin
            // A zero bit in the written nibble leaves its flag alone unless bit 0 of the nibble is set
            clr_mask = clr;
            if (clr.any_event) begin
                clr_mask = '1;
            end
        end

        state_next       = state_reg;
        // Set after clear so a same-cycle event survives
        state_next.flags = (state_reg.flags & ~clr_mask) | set_mask;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flags = state_reg.flags;

endmodule

`default_nettype wire

/* File: dfc_flag_clear.sv */
// APB-facing DMA event status, flag-clear register and interrupt logic.
`default_nettype none

module dfc_flag_clear
    import dfc_pkg::*;
(
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [31:0]    paddr,
    input  wire logic [31:0]    pwdata,
    input  wire logic [3:0]     pstrb,
    output var  logic [31:0]    prdata,
    output var  logic           pready,
    output var  logic           pslverr,
    input  wire dfc_evt_t [7:0] chan_evt,
    input  wire logic [31:0]    chan_rdata,
    output var  logic           chan_req,
    output var  logic           chan_write,
    output var  logic [2:0]     chan_idx,
    output var  logic [2:0]     chan_word,
    output var  logic [31:0]    chan_wdata,
    output var  logic [31:0]    event_status,
    output var  logic           irq
);

    dfc_top_state_t       state_reg;
    dfc_top_state_t       state_next;
    dfc_flags_t     [7:0] flags;
    logic           [31:0] status_word;
    logic           [31:0] clear_word;
    logic                  setup_phase;
    logic                  access_end;
    logic                  clr_write;
    logic           [7:0]  clr_en;
    dfc_chan_hit_t         chan_hit;
    logic                  hit_status;
    logic                  hit_clear;
    logic                  hit_mask;
    logic                  aligned;

    // Locate an address inside the per-channel register blocks
    function automatic dfc_chan_hit_t chan_decode(input logic [31:0] addr);
        dfc_chan_hit_t r;
        logic [31:0]   lo;
        logic [31:0]   rel;
        r = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            lo = CH0_BASE + 32'(i) * CH_STRIDE;
            if (addr >= lo && addr < lo + CH_STRIDE) begin
                rel    = addr - lo;
                r.hit  = 1'b1;
                r.idx  = 3'(i);
                r.word = rel[4:2];
            end
        end
        return r;
    endfunction

    // Byte lane of a channel nibble; a lane holds two channels
    function automatic logic lane_of(input logic [3:0] strb, input int ch);
        return strb[ch / 2];
    endfunction

    assign setup_phase = psel && !penable;
    // One wait state: pready rises on the second access cycle
    assign access_end  = psel && penable && state_reg.pready;
    assign aligned     = (paddr[1:0] == 2'b00);
    assign hit_status  = aligned && (paddr == DMA_BASE + STATUS_OFFSET);
    assign hit_clear   = aligned && (paddr == DMA_BASE + CLEAR_OFFSET);
    assign hit_mask    = aligned && (paddr == DMA_BASE + MASK_OFFSET);
    assign chan_hit    = chan_decode(paddr);

    // The clear word exists only as the write data of one access
    assign clear_word  = pwdata;
    assign clr_write   = access_end && pwrite && hit_clear;

    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
            assign clr_en[ch] = clr_write && lane_of(pstrb, ch);
            assign status_word[FLAGS_PER_CH*ch +: FLAGS_PER_CH] = flags[ch];

            dfc_flag_cell u_cell (
                .pclk    (pclk),
                .presetn (presetn),
                .evt     (chan_evt[ch]),
                .clr_en  (clr_en[ch]),
                .clr     (dfc_flags_t'(clear_word[FLAGS_PER_CH*ch +: FLAGS_PER_CH])),
                .flags   (flags[ch])
            );
        end
    endgenerate

    always_comb begin
        state_next            = state_reg;
        state_next.chan_req   = 1'b0;
        state_next.irq        = |(status_word & state_reg.mask);

        if (access_end) begin
            // Answer is consumed at this edge; drop back for the next transfer
            state_next.pready  = 1'b0;
            state_next.pslverr = 1'b0;
            state_next.prdata  = '0;
            if (pwrite && hit_mask) begin
                for (int b = 0; b < 4; b++) begin
                    if (pstrb[b]) begin
                        state_next.mask[8*b +: 8] = pwdata[8*b +: 8];
                    end
                end
            end
        end else if (psel && penable && !state_reg.pready) begin
            state_next.pready  = 1'b1;
            state_next.pslverr = 1'b0;
            state_next.prdata  = '0;
            if (hit_status) begin
                // Flags only change through events and the clear register
                state_next.prdata  = pwrite ? '0 : status_word;
                state_next.pslverr = pwrite;
            end else if (hit_clear) begin
                state_next.prdata = '0;
            end else if (hit_mask) begin
                state_next.prdata = pwrite ? '0 : state_reg.mask;
            end else if (aligned && chan_hit.hit && chan_hit.word < CH_WORDS) begin
                // Channel register file answers combinationally on chan_rdata
                state_next.prdata = pwrite ? '0 : chan_rdata;
            end else begin
                state_next.pslverr = 1'b1;
            end
        end

        // Forward a channel block access one cycle after its setup
        if (setup_phase && aligned && chan_hit.hit && chan_hit.word < CH_WORDS) begin
            state_next.chan_req   = 1'b1;
            state_next.chan_write = pwrite;
            state_next.chan_idx   = chan_hit.idx;
            state_next.chan_word  = chan_hit.word;
            state_next.chan_wdata = pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg      <= '0;
            state_reg.mask <= MASK_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata       = state_reg.prdata;
    assign pready       = state_reg.pready;
    assign pslverr      = state_reg.pslverr;
    assign chan_req     = state_reg.chan_req;
    assign chan_write   = state_reg.chan_write;
    assign chan_idx     = state_reg.chan_idx;
    assign chan_word    = state_reg.chan_word;
    assign chan_wdata   = state_reg.chan_wdata;
    assign event_status = status_word;
    assign irq          = state_reg.irq;

endmodule

`default_nettype wire

/* File: dfc_flag_clear_properties.sv */
// Port-level assertions for the DMA flag-clear block.
`default_nettype none
module dfc_flag_clear_properties
    import dfc_pkg::*;
(
    input wire logic           pclk,
    input wire logic           presetn,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [31:0]    paddr,
    input wire logic [31:0]    pwdata,
    input wire logic [3:0]     pstrb,
    input wire logic [31:0]    prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    input wire dfc_evt_t [7:0] chan_evt,
    input wire logic           chan_req,
    input wire logic [2:0]     chan_idx,
    input wire logic [31:0]    event_status
);
    logic [31:0] wipe;
    logic [31:0] set32;
    logic        clr_wr;
    // A global clear bit widens to the whole nibble
    always_comb begin
        for (int n = 0; n < NUM_CH; n++) begin
            wipe[4*n +: 4]  = pwdata[4*n] ? 4'hf : pwdata[4*n +: 4];
            set32[4*n +: 4] = {chan_evt[n], |chan_evt[n]};
        end
    end
    assign clr_wr = psel && penable && pready && pwrite && pstrb == 4'hf
                    && paddr == DMA_BASE + CLEAR_OFFSET;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    clear_ones_a: assert property (
        clr_wr && chan_evt == '0 |=> (event_status & $past(wipe)) == '0)
        else $error("Cleared flags still set");
    zero_keep_a: assert property (
        clr_wr && chan_evt == '0 |=> event_status == ($past(event_status) & ~$past(wipe)))
        else $error("Flags changed without a one");
    evt_set_a: assert property (
        |set32 |=> (event_status & $past(set32)) == $past(set32))
        else $error("Event flag not set");
    no_spurious_a: assert property (
        1'b1 |=> (event_status & ~$past(event_status) & ~$past(set32)) == '0)
        else $error("Flag set without event");
    clear_reads_a: assert property (
        psel && penable && pready && !pwrite && paddr == DMA_BASE + CLEAR_OFFSET
        |-> prdata == '0 && !pslverr)
        else $error("Clear register read not zero");
    status_ro_a: assert property (
        psel && penable && pready && pwrite && paddr == DMA_BASE |-> pslverr)
        else $error("Status write accepted");
    wait_state_a: assert property (
        psel && penable && !pready && $past(psel) && !$past(penable) |=> pready)
        else $error("Ready not after one wait state");
    chan_fwd_a: assert property (
        psel && !penable && paddr == CH_LAST_BASE |=> chan_req && chan_idx == 3'h7)
        else $error("Last channel block not forwarded");
endmodule
bind dfc_flag_clear dfc_flag_clear_properties u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_evt(chan_evt), .chan_req(chan_req), .chan_idx(chan_idx),
    .event_status(event_status));
`default_nettype wire

/* File: dfc_flag_clear_test.sv */
// Directed APB bench for the DMA flag-clear block.
`default_nettype none
module dfc_flag_clear_test
    import dfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, fwd;
    logic           chan_req, chan_write;
    logic [31:0]    paddr, pwdata, prdata, chan_rdata, chan_wdata, event_status, rd;
    logic [3:0]     pstrb;
    logic [2:0]     chan_idx, chan_word;
    dfc_evt_t [7:0] chan_evt, ev;
    int             fails, samples_checked;
    dfc_flag_clear dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan_evt(chan_evt), .chan_rdata(chan_rdata),
        .chan_req(chan_req), .chan_write(chan_write), .chan_idx(chan_idx),
        .chan_word(chan_word), .chan_wdata(chan_wdata), .event_status(event_status),
        .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Request held until pready is sampled high; no fixed latency assumed
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        fwd = 1'b0;
        do begin
            @(posedge pclk);
            n++;
            // Forward pulse stands one cycle, so catch it while waiting
            if (chan_req === 1'b1) fwd = 1'b1;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) fails++;
    endtask
    task automatic pulse(input dfc_evt_t [7:0] v);
        @(posedge pclk);
        chan_evt <= v;
        @(posedge pclk);
        chan_evt <= '0;
        @(posedge pclk);
    endtask
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
        pwdata = '0; pstrb = 4'hf; chan_evt = '0; chan_rdata = 32'h5a5a_0011; ev = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk("status at reset", STATUS_RESET, event_status);
        apb(1'b0, DMA_BASE + CLEAR_OFFSET, '0);
        chk("clear reg read", CLEAR_RESET, rd);
        pulse('1);
        chk("all flags", 32'hffff_ffff, event_status);
        apb(1'b1, DMA_BASE + MASK_OFFSET, 32'hffff_ffff);
        repeat (2) @(posedge pclk);
        chk("irq raised", 32'h1, irq);
        apb(1'b1, DMA_BASE + CLEAR_OFFSET, 32'h0af0_8421);
        @(posedge pclk);
        chk("mixed clear", 32'hf50f_7bd0, event_status);
        apb(1'b0, DMA_BASE + STATUS_OFFSET, '0);
        chk("status read", 32'hf50f_7bd0, rd);
        apb(1'b1, DMA_BASE + STATUS_OFFSET, '0);
        chk("status write err", 32'h1, err);
        apb(1'b0, DMA_BASE + 32'h0000_00ac, '0);
        chk("unmapped err", 32'h1, err);
        apb(1'b0, CH_LAST_BASE, '0);
        chk("channel access err", 32'h0, err);
        chk("channel read data", 32'h5a5a_0011, rd);
        chk("channel forward", 32'h1, fwd);
        chk("channel index", 32'h7, chan_idx);
        chk("channel word", 32'h0, chan_word);
        apb(1'b1, CH0_BASE + 32'h3 * CH_STRIDE + 32'h8, 32'hc0de_0042);
        chk("channel write err", 32'h0, err);
        chk("channel write fwd", 32'h1, fwd);
        chk("channel write dir", 32'h1, chan_write);
        chk("channel write index", 32'h3, chan_idx);
        chk("channel write word", 32'h2, chan_word);
        chk("channel write data", 32'hc0de_0042, chan_wdata);
        apb(1'b0, CH0_BASE + 32'h10, '0);
        chk("channel word 4 err", 32'h1, err);
        chk("channel word 4 fwd", 32'h0, fwd);
        apb(1'b1, DMA_BASE + MASK_OFFSET, '0);
        repeat (2) @(posedge pclk);
        chk("irq masked", 32'h0, irq);
        apb(1'b1, DMA_BASE + CLEAR_OFFSET, 32'h1111_1111);
        @(posedge pclk);
        chk("global clear", 32'h0, event_status);
        ev[2].complete = 1'b1;
        pulse(ev);
        chk("single event", 32'h0000_0300, event_status);
        // Event lands on the very edge that completes the clear write
        fork
            apb(1'b1, DMA_BASE + CLEAR_OFFSET, 32'h0000_0f00);
            begin
                wait (pready === 1'b1);
                chan_evt <= ev;
                @(posedge pclk);
                chan_evt <= '0;
            end
        join
        @(posedge pclk);
        chk("set beats clear", 32'h0000_0300, event_status);
        pulse('1);
        pstrb <= 4'h2;
        apb(1'b1, DMA_BASE + CLEAR_OFFSET, 32'h1111_1111);
        pstrb <= 4'hf;
        @(posedge pclk);
        chk("lane clear", 32'hffff_00ff, event_status);
        apb(1'b1, DMA_BASE + MASK_OFFSET, 32'h0000_00f0);
        apb(1'b0, DMA_BASE + MASK_OFFSET, '0);
        chk("mask read", 32'h0000_00f0, rd);
        chk("irq one channel", 32'h1, irq);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("status after reset", STATUS_RESET, event_status);
        chk("irq after reset", 32'h0, irq);
        presetn <= 1'b1;
        apb(1'b0, DMA_BASE + MASK_OFFSET, '0);
        chk("mask after reset", MASK_RESET, rd);
        test_done;
    end
    // Whole run is about a hundred cycles
    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        test_done;
    end
endmodule
`default_nettype wire
